// [shared/eppc_pkg.sv]
// Purpose: Constants for the parallel port register block and EPP engine.
// Assumes: Core clock of 125 MHz; byte-wide host register port.
// Notes:
// Notes on behaviour
// (RULE_01) Watchdog expiry in EPP mode sets timeout flag.
// (RULE_02) Timeout flag cleared by reset or writing one.
// (RULE_03) Status bits one and two read low.
// (RULE_04) Status bits 3-6 mirror fault, online, media, ack.
// (RULE_05) Status bit seven is inverted busy pin.
// (RULE_06) Status value captured once, held during read.
// (RULE_07) Reset clears control 0-5; bits 6-7 zero.
// (RULE_08) Strobe, feed, select inverted; reset pin direct.
// (RULE_09) Ack rising edge raises interrupt when enabled.
// (RULE_10) Printer mode drives out; else direction bit rules.
// (RULE_11) Address write launches cycle, byte held uninverted.
// (RULE_12) Address read captures bus at strobe release.
// (RULE_13) Data windows launch data cycles with data strobe.
// (RULE_14) EPP windows accessible only in EPP mode.
// (RULE_15) Idle EPP mode behaves like standard port.
// (RULE_16) Over ten microseconds waiting aborts, sets flag.
// (RULE_17) Strobe control bit forces write direction.
// (RULE_18) Software clears direction bit before EPP cycles.
// (RULE_19) Host access stalls until handshake completes.
// (RULE_20) Wait high at start holds strobes until low.
// (RULE_21) Write: drive byte, indicator, strobe, release.
// (RULE_22) Peripheral raises wait, latches, then lowers wait.
// (RULE_23) Peripheral wait high acknowledges, low means ready.
// (RULE_24) Watchdog counts clocks from strobe, restarts per cycle; code starts counting in EPPC_PREWAIT, before the strobe.

package eppc_pkg;
	localparam logic [2:0] EPPC_OFF_STATUS = 3'h1;
	localparam logic [2:0] EPPC_OFF_CONTROL = 3'h2;
	localparam logic [2:0] EPPC_OFF_ADDR = 3'h3;
	localparam logic [2:0] EPPC_OFF_DATA0 = 3'h4;
	localparam int EPPC_ST_WATCHDOG_EXPIRED_FLAG = 0;
	localparam int EPPC_ST_FAULT = 3;
	localparam int EPPC_ST_ONLINE = 4;
	localparam int EPPC_ST_MEDIA = 5;
	localparam int EPPC_ST_ACK = 6;
	localparam int EPPC_ST_READY = 7;
	localparam int EPPC_CT_STROBE = 0;
	localparam int EPPC_CT_FEED = 1;
	localparam int EPPC_CT_INIT = 2;
	localparam int EPPC_CT_CHOOSE = 3;
	localparam int EPPC_CT_INTERRUPT_ENABLE_BIT = 4;
	localparam int EPPC_CT_DIR = 5;
	localparam logic [5:0] EPPC_CTRL_RESET = 6'h00;
	localparam logic [7:0] EPPC_WIN_RESET = 8'h00;
	localparam int EPPC_CLK_MHZ = 125;
	localparam int EPPC_WDOG_US = 10;
	localparam int EPPC_WDOG_CYC = EPPC_WDOG_US * EPPC_CLK_MHZ;
	localparam int EPPC_FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		EPPC_MODE_SPP,
		EPPC_MODE_BIDIR,
		EPPC_MODE_EPP,
		EPPC_MODE_ECP
	} eppc_mode_t;
endpackage : eppc_pkg

// [shared/eppc_stream_if.sv]
// Purpose: Valid/ready byte stream between the port engine and its FIFO.
// Assumes: Single clock domain.
// Notes: Source drives valid and data, sink drives ready.
`timescale 1ns/1ps
`default_nettype none
interface eppc_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : eppc_stream_if
`default_nettype wire

// [hdl/eppc_fifo.sv]
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: Depth is a power of two.
// Notes: Full and empty follow the occupancy count exactly.
`timescale 1ns/1ps
`default_nettype none
module eppc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	eppc_stream_if.snk in_s,
	eppc_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	wire full = (cnt_q == (AW+1)'(DEPTH));
	wire empty = (cnt_q == '0);
	wire push = in_s.valid && !full;
	wire pop = out_s.ready && !empty;
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem_q[rp_q];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_s.data;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= push ? wp_q + 1'b1 : wp_q;
			rp_q <= pop ? rp_q + 1'b1 : rp_q;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifo_bound_a: assert property (@(posedge core_clk) disable iff (rst)
		cnt_q <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule : eppc_fifo
`default_nettype wire

// [hdl/eppc_watchdog.sv]
// Purpose: Cycle counter that flags an overlong EPP handshake.
// Assumes: Run is held for the whole cycle and dropped at its end.
// Notes: Count holds at the terminal count and expiry stays high until run drops.
`timescale 1ns/1ps
`default_nettype none
module eppc_watchdog #(
	parameter int LIMIT = 1250
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic run,
	output logic expired
);
	logic [$clog2(LIMIT+1)-1:0] cnt_q;
	localparam int CW = $clog2(LIMIT+1);
	wire at_limit = (cnt_q == CW'(LIMIT - 1));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= run ? (at_limit ? cnt_q : cnt_q + 1'b1) : '0; // RULE_24
		end
	end
	assign expired = run && at_limit; // RULE_16

	wdog_restart_a: assert property (@(posedge core_clk) // RULE_24
		disable iff (rst) !run |=> cnt_q == '0)
		else $error("watchdog did not restart between cycles");
endmodule : eppc_watchdog
`default_nettype wire

// [hdl/eppc_port.sv]
// Purpose: Parallel port status/control registers and EPP write/read engine.
// Assumes: Host access is a request held until done; inputs are synchronous.
// Notes: Host write bytes to the EPP windows in EPP mode pass through a FIFO before the EPP engine.
`timescale 1ns/1ps
`default_nettype none
module eppc_port
	import eppc_pkg::*;
#(
	parameter int WDOG_CYCLES = EPPC_WDOG_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] port_mode,
	input wire logic host_req,
	input wire logic host_wr,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic host_wait,
	output logic host_done,
	output logic [7:0] host_rdata,
	input wire logic fault_input_n,
	input wire logic online_status,
	input wire logic media_exhausted,
	input wire logic char_taken_n,
	input wire logic busy_in,
	input wire logic peripheral_wait,
	input wire logic [7:0] parallel_bus_in,
	output logic [7:0] parallel_bus_out,
	output logic parallel_bus_oe,
	output logic strobe_out_n,
	output logic line_feed_out_n,
	output logic printer_reset_n,
	output logic choose_printer_out_n,
	output logic data_strobe_line,
	output logic addr_strobe_line,
	output logic irq
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	typedef enum {
		EPPC_IDLE,
		EPPC_LOAD,
		EPPC_PREWAIT,
		EPPC_STROBE,
		EPPC_RELEASE,
		EPPC_FINISH
	} eppc_state_t;

	eppc_state_t st_q, st_d;
	logic [5:0] ctrl_q;
	logic watchdog_expired_flag_q;
	logic [7:0] addr_win_q;
	logic [7:0] data_win_q;
	logic [7:0] drive_q;
	logic is_addr_q;
	logic is_wr_q;
	logic ack_q;
	logic busy_q;
	logic done_q;
	logic [7:0] rdata_q;
	logic [7:0] bus_out_q;
	logic bus_oe_q;
	logic strobe_n_q, feed_n_q, init_q, choose_n_q;
	logic dstb_q, astb_q;
	logic irq_q;

	function automatic logic is_epp_win(input logic [2:0] a);
		is_epp_win = (a >= EPPC_OFF_ADDR);
	endfunction : is_epp_win

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire epp_mode = (port_mode == EPPC_MODE_EPP);
	wire new_req = host_req && !busy_q && !done_q;
	wire epp_hit = epp_mode && is_epp_win(host_addr); // RULE_14
	wire start_epp = new_req && epp_hit;
	wire simple_acc = new_req && !epp_hit;
	wire wr_ctrl = simple_acc && host_wr && host_addr == EPPC_OFF_CONTROL;
	wire wr_stat = simple_acc && host_wr && host_addr == EPPC_OFF_STATUS;
	wire in_cycle = (st_q != EPPC_IDLE);
	wire force_wr = ctrl_q[EPPC_CT_STROBE]; // RULE_17
	// Direction bit left set turns a write into a read on the bus.
	wire eff_wr = force_wr || (is_wr_q && !ctrl_q[EPPC_CT_DIR]); // RULE_18
	wire [7:0] status_now = {!busy_in, char_taken_n, media_exhausted,
		online_status, fault_input_n, 2'b00, watchdog_expired_flag_q}; // RULE_03 RULE_04 RULE_05
	wire wd_exp;
	wire wd_run = (st_q == EPPC_PREWAIT) || (st_q == EPPC_STROBE)
		|| (st_q == EPPC_RELEASE);
	wire spp_out = (port_mode == EPPC_MODE_SPP) || !ctrl_q[EPPC_CT_DIR];
	wire ack_rise = char_taken_n && !ack_q;
	logic [7:0] simple_rd;

	always_comb begin
		case (host_addr)
			EPPC_OFF_STATUS: simple_rd = status_now;
			EPPC_OFF_CONTROL: simple_rd = {2'b00, ctrl_q}; // RULE_07
			default: simple_rd = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Write FIFO between host and EPP bus
	// ------------------------------------------------------------
	eppc_stream_if #(.W(8)) fin ();
	eppc_stream_if #(.W(8)) fout ();
	assign fin.valid = start_epp && host_wr;
	assign fin.data = host_wdata;
	assign fout.ready = (st_q == EPPC_LOAD);

	eppc_fifo #(.W(8), .DEPTH(EPPC_FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_s(fin.snk),
		.out_s(fout.src)
	);

	eppc_watchdog #(.LIMIT(WDOG_CYCLES)) u_wdog (
		.core_clk(core_clk),
		.rst(rst),
		.run(wd_run),
		.expired(wd_exp)
	);

	// ------------------------------------------------------------
	// EPP handshake sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			EPPC_IDLE: st_d = start_epp ? EPPC_LOAD : EPPC_IDLE;
			EPPC_LOAD: begin
				if (!is_wr_q || fout.valid) begin
					st_d = EPPC_PREWAIT;
				end
			end
			EPPC_PREWAIT: begin
				if (wd_exp) begin
					st_d = EPPC_FINISH; // RULE_16
				end else if (!peripheral_wait) begin
					st_d = EPPC_STROBE; // RULE_20
				end
			end
			EPPC_STROBE: begin
				if (wd_exp) begin
					st_d = EPPC_FINISH;
				end else if (peripheral_wait) begin
					st_d = EPPC_RELEASE; // RULE_19
				end
			end
			EPPC_RELEASE: st_d = EPPC_FINISH; // RULE_21
			EPPC_FINISH: st_d = EPPC_IDLE;
			default: st_d = EPPC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= EPPC_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			is_addr_q <= 1'b0;
			is_wr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			busy_q <= start_epp || (busy_q && st_q != EPPC_FINISH);
			done_q <= simple_acc || (st_q == EPPC_FINISH)
				|| (done_q && host_req);
			is_addr_q <= start_epp ? (host_addr == EPPC_OFF_ADDR) : is_addr_q;
			is_wr_q <= start_epp ? host_wr : is_wr_q;
		end
	end

	// ------------------------------------------------------------
	// Registers and captured data
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= EPPC_CTRL_RESET; // RULE_07
			watchdog_expired_flag_q <= 1'b0; // RULE_02
			addr_win_q <= EPPC_WIN_RESET; // RULE_11
			data_win_q <= EPPC_WIN_RESET; // RULE_13
			drive_q <= EPPC_WIN_RESET;
			rdata_q <= 8'h00;
			// The pin idles high, so reset matches it and cannot fake an edge.
			ack_q <= 1'b1;
		end else begin
			ctrl_q <= wr_ctrl ? host_wdata[5:0] : ctrl_q;
			// A timeout arriving with a clearing write still wins.
			watchdog_expired_flag_q <= (epp_mode && wd_exp)
				|| (watchdog_expired_flag_q && !(wr_stat && host_wdata[EPPC_ST_WATCHDOG_EXPIRED_FLAG])); // RULE_01 RULE_02
			drive_q <= fout.ready && fout.valid ? fout.data : drive_q; // RULE_11
			if (fout.ready && fout.valid && is_addr_q) begin
				addr_win_q <= fout.data;
			end
			if (fout.ready && fout.valid && !is_addr_q) begin
				data_win_q <= fout.data;
			end
			if (simple_acc && !host_wr) begin
				rdata_q <= simple_rd; // RULE_06
			end else if (st_q == EPPC_RELEASE && !eff_wr) begin
				rdata_q <= parallel_bus_in; // RULE_12 RULE_13
				if (is_addr_q) begin
					addr_win_q <= parallel_bus_in;
				end else begin
					data_win_q <= parallel_bus_in;
				end
			end
			ack_q <= char_taken_n;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	wire strobing = (st_q == EPPC_STROBE);
	wire epp_drv = in_cycle && st_q != EPPC_LOAD;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_out_q <= 8'h00;
			bus_oe_q <= 1'b1;
			strobe_n_q <= 1'b1;
			feed_n_q <= 1'b1;
			init_q <= 1'b0;
			choose_n_q <= 1'b1;
			dstb_q <= 1'b1;
			astb_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			bus_out_q <= epp_drv ? drive_q : data_win_q;
			bus_oe_q <= epp_drv ? eff_wr : spp_out; // RULE_10 RULE_15 RULE_17
			strobe_n_q <= epp_drv ? !eff_wr : !ctrl_q[EPPC_CT_STROBE]; // RULE_08
			feed_n_q <= !ctrl_q[EPPC_CT_FEED]; // RULE_08
			init_q <= ctrl_q[EPPC_CT_INIT]; // RULE_08
			choose_n_q <= !ctrl_q[EPPC_CT_CHOOSE]; // RULE_08
			dstb_q <= !(strobing && !is_addr_q) ; // RULE_13 RULE_21
			astb_q <= !(strobing && is_addr_q); // RULE_11 RULE_21
			irq_q <= ctrl_q[EPPC_CT_INTERRUPT_ENABLE_BIT] && ack_rise; // RULE_09
		end
	end

	assign host_wait = busy_q;
	assign host_done = done_q;
	assign host_rdata = rdata_q;
	assign parallel_bus_out = bus_out_q;
	assign parallel_bus_oe = bus_oe_q;
	assign strobe_out_n = strobe_n_q;
	assign line_feed_out_n = feed_n_q;
	assign printer_reset_n = init_q;
	assign choose_printer_out_n = choose_n_q;
	assign data_strobe_line = dstb_q;
	assign addr_strobe_line = astb_q;
	assign irq = irq_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_strobe_open;
		st_q == EPPC_STROBE;
	endsequence

	watchdog_expired_flag_set_a: assert property (@(posedge core_clk) // RULE_01
		disable iff (rst) epp_mode && wd_exp |=> watchdog_expired_flag_q)
		else $error("timeout flag not set on expiry");
	watchdog_expired_flag_clr_a: assert property (@(posedge core_clk) // RULE_02
		disable iff (rst) wr_stat && host_wdata[0] && !wd_exp
		|=> !watchdog_expired_flag_q)
		else $error("timeout flag not cleared by one");
	ctrl_top_a: assert property (@(posedge core_clk) // RULE_07
		disable iff (rst) simple_acc && !host_wr
		&& host_addr == EPPC_OFF_CONTROL |=> host_rdata[7:6] == 2'b00)
		else $error("control top bits not zero");
	status_low_a: assert property (@(posedge core_clk) // RULE_03
		disable iff (rst) simple_acc && !host_wr
		&& host_addr == EPPC_OFF_STATUS |=> host_rdata[2:1] == 2'b00
		&& host_rdata[7] == !$past(busy_in))
		else $error("status fixed bits wrong");
	rdata_hold_a: assert property (@(posedge core_clk) // RULE_06
		disable iff (rst) host_done && $past(host_done)
		|-> $stable(rdata_q))
		else $error("read data moved during read");
	irq_gate_a: assert property (@(posedge core_clk) // RULE_09
		disable iff (rst) !ctrl_q[EPPC_CT_INTERRUPT_ENABLE_BIT] |=> !irq_q)
		else $error("interrupt raised while disabled");
	wait_hold_a: assert property (@(posedge core_clk) // RULE_20
		disable iff (rst) st_q == EPPC_PREWAIT && peripheral_wait
		&& !wd_exp |=> dstb_q && astb_q)
		else $error("strobe moved while wait high");
	strobe_end_a: assert property (@(posedge core_clk) // RULE_21
		disable iff (rst) s_strobe_open ##1 st_q == EPPC_RELEASE
		|=> st_q == EPPC_FINISH ##1 done_q)
		else $error("write termination out of order");
	epp_gate_a: assert property (@(posedge core_clk) // RULE_14
		disable iff (rst) new_req && !epp_mode |=> !busy_q)
		else $error("EPP cycle outside EPP mode");
	force_wr_a: assert property (@(posedge core_clk) // RULE_17
		disable iff (rst) epp_drv && ctrl_q[0] |=> bus_oe_q)
		else $error("strobe bit did not force write");
endmodule : eppc_port
`default_nettype wire

// [bench/eppc_periph.sv]
// Purpose: Behavioural EPP peripheral on the far side of the port.
// Assumes: Strobes are active low; wait high acknowledges a transfer.
// Notes: Outside a strobe the read bus shows the inverse of its last byte.
`timescale 1ns/1ps
`default_nettype none
module eppc_periph (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic data_strobe_line,
	input wire logic addr_strobe_line,
	input wire logic [7:0] parallel_bus_out,
	input wire logic [3:0] lag,
	input wire logic hang,
	input wire logic hold,
	input wire logic [7:0] rd_byte,
	output logic peripheral_wait,
	output logic [7:0] parallel_bus_in,
	output logic [7:0] got_byte,
	output logic got_addr
);
	logic ack_q;
	logic stb_q;
	logic [3:0] cnt_q;
	logic [7:0] last_q;
	wire stb = !data_strobe_line || !addr_strobe_line;
	// Hold keeps the line high so a cycle can start against a busy device.
	assign peripheral_wait = ack_q | hold;
	// A released bus must not keep its old value, or a late capture hides.
	assign parallel_bus_in = stb ? rd_byte : ~last_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			stb_q <= 1'b0;
			cnt_q <= 4'h0;
			last_q <= 8'h00;
			got_byte <= 8'h00;
			got_addr <= 1'b0;
		end else begin
			stb_q <= stb;
			if (stb) begin
				last_q <= rd_byte;
				got_byte <= parallel_bus_out;
				got_addr <= !addr_strobe_line;
			end
			if (stb && !hang && !ack_q) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q >= lag) begin
					ack_q <= 1'b1;
				end
			end
			if (stb_q && !stb) begin
				ack_q <= 1'b0;
				cnt_q <= 4'h0;
			end
		end
	end
endmodule : eppc_periph
`default_nettype wire

// [bench/tb_epp_parallel_port_ctrl.sv]
// Purpose: Self-checking bench for the parallel port and EPP engine.
// Assumes: Watchdog shortened to 20 cycles; one host request at a time.
// Notes: Random stimulus from a fixed seed with corner cases between.
`timescale 1ns/1ps
`default_nettype none
module tb_epp_parallel_port_ctrl;
	import eppc_pkg::*;
	logic core_clk, rst, host_req, host_wr, host_wait, host_done, irq;
	logic [1:0] port_mode;
	logic [2:0] host_addr;
	logic [7:0] host_wdata, host_rdata, parallel_bus_in, parallel_bus_out;
	logic fault_input_n, online_status, media_exhausted, char_taken_n;
	logic busy_in, peripheral_wait, parallel_bus_oe, strobe_out_n;
	logic line_feed_out_n, printer_reset_n, choose_printer_out_n;
	logic data_strobe_line, addr_strobe_line, hang, hold, got_addr;
	logic [3:0] lag;
	logic [1:0] stb_pins;
	logic [7:0] rd_byte, got_byte, q, v;
	int errors, checks_done, cyc, n;
	eppc_port #(.WDOG_CYCLES(20)) i_dut (.core_clk, .rst, .port_mode,
		.host_req, .host_wr, .host_addr, .host_wdata, .host_wait, .host_done,
		.host_rdata, .fault_input_n, .online_status, .media_exhausted,
		.char_taken_n, .busy_in, .peripheral_wait, .parallel_bus_in,
		.parallel_bus_out, .parallel_bus_oe, .strobe_out_n, .line_feed_out_n,
		.printer_reset_n, .choose_printer_out_n, .data_strobe_line,
		.addr_strobe_line, .irq);
	eppc_periph i_periph (.core_clk, .rst, .data_strobe_line,
		.addr_strobe_line, .parallel_bus_out, .lag, .hang, .hold, .rd_byte,
		.peripheral_wait, .parallel_bus_in, .got_byte, .got_addr);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Write indicator and bus enable as seen while the data strobe is low.
	always @(posedge core_clk) begin
		if (!data_strobe_line) begin
			stb_pins <= {strobe_out_n, parallel_bus_oe};
		end
	end
	task automatic finish_test;
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Outputs are read at the edge, before that edge's updates land.
	task automatic acc(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int k;
		host_req <= 1'b1;
		host_wr <= w;
		host_addr <= a;
		host_wdata <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (host_done !== 1'b1 && k < 400);
		check(8'(k < 400), 8'h01);
		r = host_rdata;
		host_req <= 1'b0;
		@(posedge core_clk);
	endtask : acc
	function automatic logic [7:0] exp_status(input logic tm);
		return {~busy_in, char_taken_n, media_exhausted, online_status,
			fault_input_n, 2'b00, tm};
	endfunction : exp_status
	task automatic irq_try(output int cnt);
		char_taken_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		char_taken_n <= 1'b1;
		cnt = 0;
		repeat (6) begin
			@(posedge core_clk);
			if (irq === 1'b1) cnt++;
		end
	endtask : irq_try
	initial begin
		cyc = 0;
		forever begin
			@(posedge core_clk);
			cyc++;
			if (cyc > 20000) begin
				errors++;
				finish_test();
			end
		end
	end
	initial begin
		{rst, host_req, host_wr, host_addr, host_wdata} = {1'b1, 13'h0};
		{fault_input_n, online_status, media_exhausted} = 3'h0;
		{char_taken_n, busy_in, hang, hold, lag, rd_byte} = 16'h0;
		port_mode = EPPC_MODE_SPP;
		errors = 0;
		checks_done = 0;
		v = 8'($urandom(32'h0173));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		check({4'h0, strobe_out_n, line_feed_out_n, printer_reset_n,
			choose_printer_out_n}, 8'h0d);
		acc(1'b0, EPPC_OFF_CONTROL, 8'h00, q);
		check(q, 8'h00);
		repeat (8) begin
			{fault_input_n, online_status, media_exhausted, char_taken_n,
				busy_in} <= 5'($urandom);
			@(posedge core_clk);
			acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
			check(q, exp_status(1'b0));
		end
		char_taken_n <= 1'b1;
		repeat (8) begin
			v = 8'($urandom);
			n = $urandom % 2;
			port_mode <= 2'(n);
			acc(1'b1, EPPC_OFF_CONTROL, v, q);
			acc(1'b0, EPPC_OFF_CONTROL, 8'h00, q);
			check(q, {2'b00, v[5:0]});
			check({4'h0, strobe_out_n, line_feed_out_n, printer_reset_n,
				choose_printer_out_n}, {4'h0, ~v[0], ~v[1], v[2], ~v[3]});
			check({7'h0, parallel_bus_oe}, {7'h0, n ? ~v[5] : 1'b1});
		end
		acc(1'b1, EPPC_OFF_CONTROL, 8'h10, q);
		irq_try(n);
		check(8'(n), 8'h01);
		acc(1'b1, EPPC_OFF_CONTROL, 8'h00, q);
		irq_try(n);
		check(8'(n), 8'h00);
		port_mode <= EPPC_MODE_EPP;
		// Direction bit cleared before any EPP cycle is issued.
		acc(1'b1, EPPC_OFF_CONTROL, 8'h04, q);
		for (int a = 3; a < 8; a++) begin
			v = 8'($urandom);
			lag <= 4'($urandom % 12);
			acc(1'b1, 3'(a), v, q);
			check(got_byte, v);
			check({7'h0, got_addr}, {7'h0, a == 3});
			rd_byte <= 8'($urandom);
			@(posedge core_clk);
			acc(1'b0, 3'(a), 8'h00, q);
			check(q, rd_byte);
		end
		check({7'h0, printer_reset_n}, 8'h01);
		acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
		check(q, exp_status(1'b0));
		// Direction bit left set: the write shows up as a read, no error.
		acc(1'b1, EPPC_OFF_CONTROL, 8'h24, q);
		acc(1'b1, EPPC_OFF_DATA0, 8'h3c, q);
		check({6'h0, stb_pins}, 8'h02);
		acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
		check(q, exp_status(1'b0));
		// Strobe bit set: a read is forced into write direction.
		acc(1'b1, EPPC_OFF_CONTROL, 8'h05, q);
		acc(1'b0, EPPC_OFF_DATA0, 8'h00, q);
		check({6'h0, stb_pins}, 8'h01);
		acc(1'b1, EPPC_OFF_CONTROL, 8'h04, q);
		v = 8'($urandom);
		// No lag here: the held wait already uses half the watchdog.
		lag <= 4'h0;
		hold <= 1'b1;
		fork
			acc(1'b1, EPPC_OFF_DATA0, v, q);
			begin
				repeat (10) begin
					@(posedge core_clk);
					check({6'h0, data_strobe_line, addr_strobe_line}, 8'h03);
				end
				hold <= 1'b0;
			end
		join
		check(got_byte, v);
		hang <= 1'b1;
		acc(1'b1, EPPC_OFF_DATA0, 8'h5a, q);
		hang <= 1'b0;
		acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
		check(q, exp_status(1'b1));
		acc(1'b1, EPPC_OFF_STATUS, 8'h00, q);
		acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
		check(q, exp_status(1'b1));
		acc(1'b1, EPPC_OFF_STATUS, 8'h01, q);
		acc(1'b0, EPPC_OFF_STATUS, 8'h00, q);
		check(q, exp_status(1'b0));
		port_mode <= EPPC_MODE_SPP;
		v = got_byte;
		acc(1'b1, EPPC_OFF_ADDR, ~v, q);
		check(got_byte, v);
		acc(1'b0, EPPC_OFF_DATA0, 8'h00, q);
		check(q, 8'h00);
		finish_test();
	end
endmodule : tb_epp_parallel_port_ctrl
`default_nettype wire
